//--- src/sub_alu_pkg.sv
// Shared constants for the subtract instruction datapath
package sub_alu_pkg;
  // APB register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_FILE_DATA = 8'h10;
  localparam logic [7:0] OFF_FILE_ADDR = 8'h14;
  // Status bit positions
  localparam int STAT_NO_BORROW = 0;
  localparam int STAT_HALF = 1;
  localparam int STAT_ZERO = 2;
  localparam int STAT_BUSY = 3;
  // Opcode fields of a 14-bit instruction word
  localparam logic [4:0] OPC_LITERAL = 5'h1E;
  localparam logic [5:0] OPC_REGFILE = 6'h02;
  localparam int TARGET_BIT = 7;
  // Reset values and register file depth
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [13:0] INSTR_RESET = 14'h0000;
  localparam int FILE_DEPTH = 128;
  // Phases of one instruction cycle, Gray coded
  typedef enum logic [1:0] {
    PH_ONE = 2'b00,
    PH_TWO = 2'b01,
    PH_THREE = 2'b11,
    PH_FOUR = 2'b10
  } phase_t;
endpackage : sub_alu_pkg

//--- src/sub_core.sv
// Eight-bit subtractor producing difference and inverted borrow flags
`timescale 1ns/1ps
module sub_core #(
  parameter int WIDTH = 8
) (
  // Operands
  input wire logic [WIDTH-1:0] minuend,
  input wire logic [WIDTH-1:0] subtrahend,
  // Results
  output logic [WIDTH-1:0] diff,
  output logic no_borrow,
  output logic half_no_borrow,
  output logic is_zero
);
  logic [WIDTH:0] full;
  logic [4:0] low;
  // Wraps modulo 2^WIDTH; extra bit is the borrow
  assign full = {1'b0, minuend} - {1'b0, subtrahend};
  assign low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
  assign diff = full[WIDTH-1:0];
  assign no_borrow = ~full[WIDTH];
  assign half_no_borrow = ~low[4];
  assign is_zero = (full[WIDTH-1:0] == '0);
endmodule : sub_core

//--- src/subtract_instruction_alu.sv
// Subtract instruction execution unit with APB register access
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module subtract_instruction_alu #(
  parameter int DEPTH = sub_alu_pkg::FILE_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction status
  output logic busy,
  output logic illegal
);
  sub_alu_pkg::phase_t phase;
  logic [13:0] instr;
  logic [7:0] acc;
  logic [7:0] operand;
  logic [7:0] result;
  logic [2:0] flags;
  logic [4:0] other_status;
  logic [6:0] file_addr;
  logic [7:0] regfile [DEPTH];
  logic [7:0] diff;
  logic nb;
  logic hnb;
  logic zr;
  logic is_lit;
  logic is_reg;
  logic wr;
  logic rd;
  logic start;
  logic bad_addr;

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign is_lit = (instr[13:9] == sub_alu_pkg::OPC_LITERAL);
  assign is_reg = (instr[13:8] == sub_alu_pkg::OPC_REGFILE);
  assign start = wr && paddr == sub_alu_pkg::OFF_CTRL && pwdata[0] && !busy;
  assign bad_addr = paddr > sub_alu_pkg::OFF_FILE_ADDR || paddr[1:0] != 2'b00;
  assign pslverr = psel & penable & bad_addr;

  sub_core #(
    .WIDTH(8)
  ) u_sub (
    .minuend(operand),
    .subtrahend(acc),
    .diff(diff),
    .no_borrow(nb),
    .half_no_borrow(hnb),
    .is_zero(zr)
  );

  // Phase sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= sub_alu_pkg::PH_ONE;
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
      phase <= sub_alu_pkg::PH_ONE;
    end else if (busy) begin
      unique case (phase)
        sub_alu_pkg::PH_ONE: phase <= sub_alu_pkg::PH_TWO;
        sub_alu_pkg::PH_TWO: phase <= sub_alu_pkg::PH_THREE;
        sub_alu_pkg::PH_THREE: phase <= sub_alu_pkg::PH_FOUR;
        sub_alu_pkg::PH_FOUR: begin
          phase <= sub_alu_pkg::PH_ONE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // Decode in phase one; unknown opcodes do nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      illegal <= 1'b0;
    end else if (busy && phase == sub_alu_pkg::PH_ONE) begin
      illegal <= !(is_lit || is_reg);
    end
  end

  // Operand read in phase two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand <= 8'h00;
    end else if (busy && phase == sub_alu_pkg::PH_TWO) begin
      if (is_lit) begin
        operand <= instr[7:0];
      end else if (is_reg) begin
        // Unknown opcodes leave the file alone; its words may be unset
        operand <= regfile[instr[6:0]];
      end
    end
  end

  // Compute in phase three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= 8'h00;
      flags <= 3'h0;
    end else if (busy && phase == sub_alu_pkg::PH_THREE) begin
      result <= diff;
      flags <= {zr, hnb, nb};
    end
  end

  // Accumulator: phase-four writeback or software load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= sub_alu_pkg::ACC_RESET;
    end else if (busy && phase == sub_alu_pkg::PH_FOUR && !illegal &&
                 (is_lit || !instr[sub_alu_pkg::TARGET_BIT])) begin
      acc <= result;
    end else if (wr && !busy && paddr == sub_alu_pkg::OFF_ACC) begin
      acc <= pwdata[7:0];
    end
  end

  // Status flags; upper bits only change by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      other_status <= 5'h00;
    end else if (wr && !busy && paddr == sub_alu_pkg::OFF_STATUS) begin
      other_status <= pwdata[7:3];
    end
  end

  logic [2:0] stat_flags;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_flags <= 3'h0;
    end else if (busy && phase == sub_alu_pkg::PH_FOUR && !illegal) begin
      stat_flags <= flags;
    end else if (wr && !busy && paddr == sub_alu_pkg::OFF_STATUS) begin
      stat_flags <= pwdata[2:0];
    end
  end

  // Instruction and file address registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr <= sub_alu_pkg::INSTR_RESET;
      file_addr <= 7'h00;
    end else if (wr && !busy) begin
      if (paddr == sub_alu_pkg::OFF_INSTR) begin
        instr <= pwdata[13:0];
      end
      if (paddr == sub_alu_pkg::OFF_FILE_ADDR) begin
        file_addr <= pwdata[6:0];
      end
    end
  end

  // Register file; no reset so it maps to plain memory
  always_ff @(posedge pclk) begin
    if (busy && phase == sub_alu_pkg::PH_FOUR && !illegal && is_reg &&
        instr[sub_alu_pkg::TARGET_BIT]) begin
      regfile[instr[6:0]] <= result;
    end else if (wr && !busy && paddr == sub_alu_pkg::OFF_FILE_DATA) begin
      regfile[file_addr] <= pwdata[7:0];
    end
  end

  // Read data registered at the end of the setup phase (psel high, penable low)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        sub_alu_pkg::OFF_CTRL: prdata <= {30'h0, illegal, busy};
        sub_alu_pkg::OFF_INSTR: prdata <= {18'h0, instr};
        sub_alu_pkg::OFF_ACC: prdata <= {24'h0, acc};
        sub_alu_pkg::OFF_STATUS: prdata <= {24'h0, other_status, stat_flags};
        sub_alu_pkg::OFF_FILE_DATA: prdata <= {24'h0, regfile[file_addr]};
        sub_alu_pkg::OFF_FILE_ADDR: prdata <= {25'h0, file_addr};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Assertions
  a_four_phase: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(busy) |-> busy [*4] ##1 !busy)
    else $error("instruction not four phases");
  a_phase_order: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy && phase == sub_alu_pkg::PH_TWO |=> phase == sub_alu_pkg::PH_THREE)
    else $error("phase order broken");
  a_lit_writes: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy && phase == sub_alu_pkg::PH_FOUR && is_lit && !illegal
    |=> acc == $past(result))
    else $error("literal result not in accumulator");
  a_zero_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy && phase == sub_alu_pkg::PH_THREE
    |=> flags[2] == (result == 8'h00))
    else $error("zero flag mismatch");
  a_borrow_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy && phase == sub_alu_pkg::PH_THREE
    |=> flags[0] == ($past(operand) >= $past(acc)))
    else $error("no-borrow flag mismatch");
  a_wrap_value: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy && phase == sub_alu_pkg::PH_THREE && operand < acc
    |=> result == 8'(($past(operand) + 9'h100) - $past(acc)) && !flags[0])
    else $error("wrap result wrong");
  a_half_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy && phase == sub_alu_pkg::PH_THREE
    |=> flags[1] == ($past(operand[3:0]) >= $past(acc[3:0])))
    else $error("half flag mismatch");
  a_status_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy |=> $stable(other_status))
    else $error("other status bits changed");
  a_reg_target: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy && phase == sub_alu_pkg::PH_FOUR && is_reg &&
    instr[sub_alu_pkg::TARGET_BIT] |=> $stable(acc))
    else $error("accumulator written for file target");
  a_lit_operand: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy && phase == sub_alu_pkg::PH_TWO && is_lit
    |=> operand == $past(instr[7:0]))
    else $error("literal operand wrong");
endmodule : subtract_instruction_alu

//--- tb/apb_host.sv
// APB master model standing for the core's decode side
`timescale 1ns/1ps
module apb_host (
  // Clock
  input wire logic pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle bus must not keep showing the old data
    pwdata <= ~d;
  endtask : xfer
endmodule : apb_host

//--- tb/tb_top.sv
// Self-checking bench for the subtract instruction unit
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, busy, illegal, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int errors = 0;
  int n_tests = 0;
  always #50 pclk = ~pclk;
  apb_host i_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  subtract_instruction_alu i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .illegal(illegal));
  task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h00000000, rd, err);
  endtask : rdr
  // Flags: zero, half no-borrow, no-borrow
  function automatic logic [2:0] flags(input logic [7:0] m, s);
    logic [7:0] d;
    d = m - s;
    return {d == 8'h00, m[3:0] >= s[3:0], m >= s};
  endfunction : flags
  task automatic run(input logic [13:0] ins);
    int n;
    wr(sub_alu_pkg::OFF_INSTR, {18'h00000, ins});
    wr(sub_alu_pkg::OFF_CTRL, 32'h00000001);
    #1;
    n = 0;
    while (busy === 1'b1 && n < 20) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("busy cycles", 32'h00000004, 32'(n));
  endtask : run
  task automatic test_reset_bad;
    rdr(sub_alu_pkg::OFF_ACC);
    chk("acc reset", {24'h000000, sub_alu_pkg::ACC_RESET}, rd);
    chk("err good", 32'h00000000, {31'h0, err});
    rdr(8'h18);
    chk("err far", 32'h00000001, {31'h0, err});
    chk("rd far", 32'h00000000, rd);
    rdr(8'h02);
    chk("err unaligned", 32'h00000001, {31'h0, err});
  endtask : test_reset_bad
  task automatic test_illegal;
    wr(sub_alu_pkg::OFF_ACC, 32'h0000005A);
    wr(sub_alu_pkg::OFF_STATUS, 32'h00000005);
    run(14'h3FFF);
    chk("illegal", 32'h00000001, {31'h0, illegal});
    rdr(sub_alu_pkg::OFF_ACC);
    chk("acc kept", 32'h0000005A, rd);
    rdr(sub_alu_pkg::OFF_STATUS);
    chk("status kept", 32'h00000005, rd);
    rdr(sub_alu_pkg::OFF_CTRL);
    chk("ctrl illegal", 32'h00000002, rd);
    rdr(sub_alu_pkg::OFF_INSTR);
    chk("instr", 32'h00003FFF, rd);
  endtask : test_illegal
  // Literal form; odd entries set the ignored opcode bit
  task automatic test_literal;
    logic [7:0] k [5] = '{8'h02, 8'h02, 8'h02, 8'h10, 8'hFF};
    logic [7:0] a [5] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h0F};
    for (int i = 0; i < 5; i++) begin
      wr(sub_alu_pkg::OFF_ACC, {24'h000000, a[i]});
      wr(sub_alu_pkg::OFF_STATUS, 32'h000000F8);
      run({5'h1E, i[0], k[i]});
      chk("illegal", 32'h00000000, {31'h0, illegal});
      rdr(sub_alu_pkg::OFF_ACC);
      chk("acc", {24'h000000, k[i] - a[i]}, rd);
      rdr(sub_alu_pkg::OFF_STATUS);
      chk("status", {24'h0, 5'h1F, flags(k[i], a[i])}, rd);
    end
  endtask : test_literal
  task automatic test_regfile;
    logic [7:0] f [3] = '{8'h03, 8'h02, 8'h01};
    logic [6:0] ad [3] = '{7'h05, 7'h7F, 7'h00};
    logic t [3] = '{1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++) begin
      wr(sub_alu_pkg::OFF_FILE_ADDR, {25'h0, ad[i]});
      wr(sub_alu_pkg::OFF_FILE_DATA, {24'h000000, f[i]});
      wr(sub_alu_pkg::OFF_ACC, 32'h00000002);
      run({6'h02, t[i], ad[i]});
      rdr(sub_alu_pkg::OFF_ACC);
      chk("acc", {24'h0, t[i] ? 8'h02 : f[i] - 8'h02}, rd);
      rdr(sub_alu_pkg::OFF_FILE_DATA);
      chk("file", {24'h0, t[i] ? f[i] - 8'h02 : f[i]}, rd);
      rdr(sub_alu_pkg::OFF_STATUS);
      chk("status", {29'h0, flags(f[i], 8'h02)}, rd[2:0]);
      rdr(sub_alu_pkg::OFF_FILE_ADDR);
      chk("file addr", {25'h0, ad[i]}, rd);
    end
  endtask : test_regfile
  // A write that lands while busy is dropped without an error
  task automatic test_busy_refuse;
    wr(sub_alu_pkg::OFF_ACC, 32'h00000007);
    wr(sub_alu_pkg::OFF_INSTR, {18'h00000, 5'h1E, 1'b0, 8'h09});
    wr(sub_alu_pkg::OFF_CTRL, 32'h00000001);
    wr(sub_alu_pkg::OFF_ACC, 32'h00000033);
    chk("busy at refused write", 32'h00000001, {31'h0, busy});
    chk("err refused", 32'h00000000, {31'h0, err});
    rdr(sub_alu_pkg::OFF_CTRL);
    chk("ctrl done", 32'h00000000, rd);
    rdr(sub_alu_pkg::OFF_ACC);
    chk("acc after refuse", 32'h00000002, rd);
  endtask : test_busy_refuse
  task automatic print_verdict;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  // Whole run needs well under a thousand cycles
  initial begin
    #(20000 * 100);
    errors++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    test_reset_bad;
    test_illegal;
    test_literal;
    test_regfile;
    test_busy_refuse;
    print_verdict;
  end
endmodule : tb_top
